//--- bench/hims_link_assertions.sv
// Purpose: wire checks between host end and device end
// Assumes: sampled on the falling link edge, as the device does
// Notes: instantiated by tb beside the link, no bind
`timescale 1ns/100ps
module hims_link_assertions (
    input wire logic resetn_i,
    input wire logic link_clk,
    input wire hims_pkg::hims_pins_type host_pins,
    input wire logic dev_busy_n,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe_n
);
    // ====
    // Setup: one domain, so one clock and one disable
    default clocking dc @(negedge link_clk);
    endclocking
    default disable iff (!resetn_i);
    // ====
    // Wire checks
    a_sda_pull_only: assert property (
        !dev_sda_oe_n |-> !dev_sda_o && host_pins.frame_n)
        else $error("sda driven outside ack");
    a_sda_i2c_only: assert property (
        !dev_sda_oe_n |-> host_pins.serial_parallel_select && host_pins.db[11])
        else $error("sda pulled outside i2c");
    a_sda_ack_short: assert property (
        $fell(dev_sda_oe_n) |-> ##[1:4] dev_sda_oe_n)
        else $error("sda held too long");
    a_strap_low_serial: assert property (
        host_pins.serial_parallel_select |-> !host_pins.strap) else $error("strap high");
    a_busy_in_reset: assert property (
        !host_pins.rst_n |-> !dev_busy_n) else $error("ready in reset");
    a_busy_after_reset: assert property (
        $rose(host_pins.rst_n) |-> (!dev_busy_n) [*4])
        else $error("busy sequence too short");
    a_strobe_parallel: assert property (
        $fell(host_pins.wr_n) |-> !host_pins.serial_parallel_select)
        else $error("strobe in serial mode");
    a_frame_serial_len: assert property (
        $fell(host_pins.frame_n) |-> host_pins.serial_parallel_select ##1
        (!host_pins.frame_n) [*8]) else $error("frame too short");
    // Main scenarios reached
    c_write: cover property ($fell(host_pins.wr_n));
    c_frame: cover property ($fell(host_pins.frame_n));
    c_ack: cover property ($fell(dev_sda_oe_n));
endmodule

//--- bench/tb.sv
// Purpose: end to end bench of host end and device end
// Assumes: ends joined by hims_link_if, host makes the link clock
// Notes: each case resets, sends until refused, drains, clears and loads
`timescale 1ns/100ps
module tb;
    localparam logic [1:0] C_MODE [5] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h2};
    localparam logic C_FIFO [5] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1};
    localparam logic C_FAST [5] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h1};
    localparam logic [23:0] C_BASE [5] = '{24'h00_3800, 24'hA5_3A55,
        24'hA5_C396, 24'h5A_3C69, 24'hC3_0F1E};
    logic clock_i = 1'b0;
    logic host_rstn = 1'b0;
    logic dev_rstn = 1'b0;
    logic [1:0] mode = 2'h0;
    logic fifo_en = 1'b0;
    logic fast = 1'b0;
    logic [23:0] word = 24'h00_0000;
    logic wvalid = 1'b0;
    logic load = 1'b0;
    logic clr = 1'b0;
    logic rready = 1'b0;
    logic wready, idle, rvalid, load_pulse, fifo_act, run, ok;
    logic [23:0] rword;
    logic [1:0] mode_seen;
    logic [23:0] got[$];
    int errors = 0;
    int n_compared = 0;
    int loads, t, n;
    hims_link_if lnk();
    hims_host hims_host_i (.clock_i(clock_i), .resetn_i(host_rstn),
        .ce_i(1'b1), .lnk(lnk.host), .mode_i(mode), .fifo_en_i(fifo_en),
        .i2c_fast_i(fast), .word_i(word), .word_valid_i(wvalid),
        .word_ready_o(wready), .load_i(load), .reset_i(1'b0),
        .clear_i(clr), .idle_o(idle));
    hims_device hims_device_i (.link_clk_i(lnk.link_clk),
        .resetn_i(dev_rstn), .ce_i(1'b1), .lnk(lnk.device),
        .word_o(rword), .word_valid_o(rvalid), .word_ready_i(rready),
        .load_pulse_o(load_pulse), .mode_o(mode_seen),
        .fifo_active_o(fifo_act), .run_o(run));
    hims_link_assertions hims_link_assertions_i (.resetn_i(dev_rstn),
        .link_clk(lnk.link_clk), .host_pins(lnk.host_pins),
        .dev_busy_n(lnk.dev_busy_n), .dev_sda_o(lnk.dev_sda_o),
        .dev_sda_oe_n(lnk.dev_sda_oe_n));
    // ====
    // Clock and device side monitor
    initial
    begin
        forever #20 clock_i = ~clock_i;
    end
    always @(negedge lnk.link_clk)
    begin
        if ((rvalid & rready) === 1'b1)
            got.push_back(rword);
        if (load_pulse === 1'b1)
            loads++;
    end
    // ====
    // Shared tasks
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ====
    // Cases: mode pins only latch while the host sits in reset
    initial
    begin
        for (int c = 0; c < 5; c++)
        begin
            @(negedge clock_i);
            host_rstn = 1'b0;
            dev_rstn = 1'b0;
            rready = 1'b0;
            mode = C_MODE[c];
            fifo_en = C_FIFO[c];
            fast = C_FAST[c];
            repeat (12) @(negedge clock_i);
            host_rstn = 1'b1;
            // Reset must span two falls of the slowest link
            repeat (400) @(negedge clock_i);
            dev_rstn = 1'b1;
            for (t = 0; t < 20000 && idle !== 1'b1; t++)
                @(negedge clock_i);
            chk(24'(idle), 24'h00_0001);
            chk(24'(mode_seen), 24'(mode));
            chk(24'(fifo_act), 24'(fifo_en & (mode == 2'h0)));
            chk(24'(run), 24'h00_0001);
            if (idle !== 1'b1)
                finish_test();
            // Stalled user side: send until the host is refused
            got.delete();
            n = 0;
            ok = 1'b1;
            while (ok && n < 9)
            begin
                word = C_BASE[c] + 24'(n);
                wvalid = 1'b1;
                ok = 1'b0;
                for (t = 0; t < 12000 && !ok; t++)
                begin
                    @(negedge clock_i);
                    ok = (wready === 1'b1);
                end
                wvalid = 1'b0;
                @(negedge clock_i);
                n = n + 32'(ok);
            end
            chk(24'(fifo_act ? (n == 8) : (n == 1)), 24'h00_0001);
            rready = 1'b1;
            for (t = 0; t < 4000 && got.size() < n; t++)
                @(negedge clock_i);
            chk(24'(got.size()), 24'(n));
            foreach (got[i])
                chk(got[i], (C_BASE[c] + 24'(i)) &
                    (mode == 2'h0 ? 24'h00_3FFF : 24'hFF_FFFF));
            loads = 0;
            load = 1'b1;
            clr = 1'b1;
            @(negedge clock_i);
            load = 1'b0;
            clr = 1'b0;
            for (t = 0; t < 12000 && loads == 0; t++)
                @(negedge clock_i);
            chk(24'(loads), 24'h00_0001);
            chk(24'(fifo_act), 24'(fifo_en & (mode == 2'h0)));
            $display("case %0d done, %0d words", c, n);
        end
        finish_test();
    end
endmodule

//--- inc/hims_link_if.sv
// Purpose: wires between host end and device end
// Assumes: bidirectional data bit 13 is resolved here as open drain
// Notes: the device clock port is wired to link_clk by the bench
`timescale 1ns/100ps
interface hims_link_if;
    hims_pkg::hims_pins_type host_pins;
    hims_pkg::hims_pins_type dev_pins;
    logic host_serial_data_bit_thirteen_oe_n;
    logic link_clk;
    logic dev_busy_n;
    logic dev_sda_o;
    logic dev_sda_oe_n;
    logic sda_line;
    // =========================================================
    // Wire resolution: released line reads high
    assign sda_line = (host_serial_data_bit_thirteen_oe_n | host_pins.db[13])
        & (dev_sda_oe_n | dev_sda_o);
    // Bit 12 carries the link clock in serial modes
    always_comb
    begin
        dev_pins = host_pins;
        dev_pins.db[13] = sda_line;
        dev_pins.db[12] = host_pins.serial_parallel_select ? link_clk : host_pins.db[12];
    end
    modport host (output host_pins, output host_serial_data_bit_thirteen_oe_n,
        output link_clk, input dev_busy_n, input sda_line);
    modport device (input dev_pins, output dev_busy_n,
        output dev_sda_o, output dev_sda_oe_n);
endinterface

//--- inc/hims_pkg.sv
// Purpose: shared constants and types of the host interface mode select
// Assumes: host on a 25 MHz clock, device on the link clock it receives
// Notes: pin bundle is the wire view between the two ends
package hims_pkg;
    // =========================================================
    // Widths and pin roles
    localparam int DB_W = 14;
    localparam int WORD_W = 24;
    localparam int FIFO_DEPTH = 8;
    localparam logic [4:0] WORD_LAST = 5'h0017;
    // =========================================================
    // Rates, link half periods in clock_i cycles (rounded up)
    localparam int CLK_HZ = 25_000_000;
    localparam int SPI_MAX_HZ = 50_000_000;
    localparam int I2C_STD_HZ = 100_000;
    localparam int I2C_FAST_HZ = 400_000;
    localparam logic [7:0] SPI_HALF =
        8'((CLK_HZ + 2 * SPI_MAX_HZ - 1) / (2 * SPI_MAX_HZ));
    localparam logic [7:0] I2C_STD_HALF =
        8'((CLK_HZ + 2 * I2C_STD_HZ - 1) / (2 * I2C_STD_HZ));
    localparam logic [7:0] I2C_FAST_HALF =
        8'((CLK_HZ + 2 * I2C_FAST_HZ - 1) / (2 * I2C_FAST_HZ));
    // =========================================================
    // Counts in link clock cycles, and the queue almost-full level in words
    localparam logic [4:0] RST_SEQ_LEN = 5'h0010;
    localparam logic [4:0] RST_HOLD = 5'h0004;
    localparam logic [4:0] GUARD_LEN = 5'h0006;
    localparam logic [1:0] ACK_LEN = 2'h2;
    localparam logic [3:0] FIFO_AFULL = 4'(FIFO_DEPTH - 1);
    // =========================================================
    // Types
    typedef enum logic [1:0] {
        MODE_PAR = 2'h0,
        MODE_SPI = 2'h1,
        MODE_I2C = 2'h2
    } hims_mode_type;
    typedef struct packed {
        logic [DB_W-1:0] db;
        logic serial_parallel_select;
        logic strap;
        logic wr_n;
        logic frame_n;
        logic load_n;
        logic rst_n;
        logic clr_n;
    } hims_pins_type;
endpackage

//--- rtl/hims_device.sv
// Purpose: device end, picks parallel, SPI or I2C host port from pins
// Assumes: clocked by the link clock, sampling on its falling edge
// Notes: all pins pass two flops, so words arrive three cycles late
`timescale 1ns/100ps
// What this block does
// RULE_01 - Strap high enables the write queue
// RULE_02 - Write queue only works in parallel mode
// RULE_03 - Strap sampled after power-up, clear, reset
// RULE_04 - Host keeps strap low in serial modes
// RULE_05 - Parallel mode: select pin is data bit 11
// RULE_06 - Serial and select low gives SPI mode
// RULE_07 - Serial and select high gives I2C mode
// RULE_08 - Parallel mode: clock pin is data bit 12
// RULE_09 - SPI bits shift in on falling clock
// RULE_10 - Host keeps SPI clock at most 50 MHz
// RULE_11 - I2C at 100 or 400 kHz, host clocks
// RULE_12 - Parallel mode: data pin is bit 13
// RULE_13 - Host holds data stable at falling edge
// RULE_14 - Device drives SDA only as open drain
// RULE_15 - Busy in reset: ports off, loads ignored
// RULE_16 - Host changes mode pins only during reset
module hims_device (
    input wire logic link_clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    hims_link_if.device lnk,
    output logic [hims_pkg::WORD_W-1:0] word_o,
    output logic word_valid_o,
    input wire logic word_ready_i,
    output logic load_pulse_o,
    output logic [1:0] mode_o,
    output logic fifo_active_o,
    output logic run_o
);
    typedef enum logic [1:0] {
        ST_SEQ = 2'b01,
        ST_RUN = 2'b10
    } hims_dst_type;
    typedef struct packed {
        hims_pkg::hims_pins_type s1;
        hims_pkg::hims_pins_type s2;
        hims_pkg::hims_pins_type s3;
        hims_dst_type st;
        logic [4:0] cnt;
        logic [1:0] mode;
        logic fifo_on;
        logic [hims_pkg::WORD_W-1:0] shift;
        logic push;
        logic [hims_pkg::WORD_W-1:0] pdata;
        logic busy_n;
        logic ack_oe_n;
        logic [1:0] ack_cnt;
        logic load;
        logic ov;
        logic [hims_pkg::WORD_W-1:0] ow;
    } hims_dev_type;
    hims_dev_type state_r;
    hims_dev_type state_nxt;
    logic fifo_clk;
    logic f_ready;
    logic f_valid;
    logic f_take;
    logic [hims_pkg::WORD_W-1:0] f_data;
    logic [3:0] f_cnt;
    logic fall_rst;
    logic fall_clr;
    logic fall_load;
    logic fall_wr;
    // =========================================================
    // Queue between the pin logic and the user side
    // Queue shares the falling-edge timing of the rest of the block
    assign fifo_clk = ~link_clk_i;
    assign f_take = !state_r.ov | word_ready_i;
    hims_fifo #(
        .W(hims_pkg::WORD_W),
        .DEPTH(hims_pkg::FIFO_DEPTH)
    ) u_queue (
        .clock_i(fifo_clk),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .in_valid_i(state_r.push),
        .in_data_i(state_r.pdata),
        .in_ready_o(f_ready),
        .out_valid_o(f_valid),
        .out_data_o(f_data),
        .out_ready_i(f_take),
        .count_o(f_cnt)
    );
    // =========================================================
    // Edge detection works on synchronised copies only
    assign fall_rst = state_r.s3.rst_n & !state_r.s2.rst_n;
    assign fall_clr = state_r.s3.clr_n & !state_r.s2.clr_n;
    assign fall_load = state_r.s3.load_n & !state_r.s2.load_n;
    assign fall_wr = state_r.s3.wr_n & !state_r.s2.wr_n;
    // =========================================================
    // Outputs straight from flops
    assign word_o = state_r.ow;
    assign word_valid_o = state_r.ov;
    assign load_pulse_o = state_r.load;
    assign mode_o = state_r.mode;
    assign fifo_active_o = state_r.fifo_on;
    assign run_o = (state_r.st == ST_RUN);
    assign lnk.dev_busy_n = state_r.busy_n;
    assign lnk.dev_sda_o = 1'b0;
    assign lnk.dev_sda_oe_n = state_r.ack_oe_n;
    // =========================================================
    // Next state
    always_comb
    begin
        state_nxt = state_r;
        state_nxt.s1 = lnk.dev_pins;
        state_nxt.s2 = state_r.s1;
        state_nxt.s3 = state_r.s2;
        state_nxt.push = 1'b0;
        state_nxt.load = 1'b0;
        // Output stage refills from the queue when free
        if (f_valid & f_take)
        begin
            state_nxt.ov = 1'b1;
            state_nxt.ow = f_data;
        end
        else if (word_ready_i)
            state_nxt.ov = 1'b0;
        // RULE_14 - release after ack
        if (state_r.ack_cnt != 2'h0)
            state_nxt.ack_cnt = state_r.ack_cnt - 1'b1;
        else
            state_nxt.ack_oe_n = 1'b1;
        case (state_r.st)
            ST_SEQ:
            begin
                // RULE_15 - busy, ports off
                if (state_r.cnt != 5'h0000)
                    state_nxt.cnt = state_r.cnt - 1'b1;
                else
                begin
                    state_nxt.st = ST_RUN;
                    // RULE_06 - pick SPI
                    // RULE_07 - pick I2C
                    if (!state_r.s2.serial_parallel_select)
                        state_nxt.mode = hims_pkg::MODE_PAR;
                    else if (!state_r.s2.db[11])
                        state_nxt.mode = hims_pkg::MODE_SPI;
                    else
                        state_nxt.mode = hims_pkg::MODE_I2C;
                    // RULE_01 - strap enables queue
                    // RULE_02 - parallel only
                    // RULE_03 - sampled here
                    state_nxt.fifo_on = state_r.s2.strap
                        & !state_r.s2.serial_parallel_select;
                end
            end
            ST_RUN:
            begin
                if (fall_rst | fall_clr)
                begin
                    state_nxt.st = ST_SEQ;
                    state_nxt.cnt = hims_pkg::RST_SEQ_LEN;
                    state_nxt.ack_oe_n = 1'b1;
                end
                else
                begin
                    // Load strobes only pass outside the busy window
                    if (fall_load)
                        state_nxt.load = 1'b1;
                    if (state_r.mode == hims_pkg::MODE_PAR)
                    begin
                        // RULE_05 - bit 11 is data
                        // RULE_08 - bit 12 is data
                        // RULE_12 - bit 13 is data
                        if (fall_wr)
                        begin
                            state_nxt.push = 1'b1;
                            state_nxt.pdata = {10'h0000, state_r.s2.db};
                        end
                    end
                    else if (state_r.s2.frame_n)
                        state_nxt.cnt = 5'h0000;
                    else
                    begin
                        // RULE_09 - shift on falling edge
                        state_nxt.shift = {state_r.shift[22:0],
                            state_r.s2.db[13]};
                        if (state_r.cnt == hims_pkg::WORD_LAST)
                        begin
                            state_nxt.cnt = 5'h0000;
                            state_nxt.push = 1'b1;
                            state_nxt.pdata = state_nxt.shift;
                            // RULE_14 - pull low to acknowledge
                            if (state_r.mode == hims_pkg::MODE_I2C)
                            begin
                                state_nxt.ack_oe_n = 1'b0;
                                state_nxt.ack_cnt = hims_pkg::ACK_LEN;
                            end
                        end
                        else
                            state_nxt.cnt = state_r.cnt + 1'b1;
                    end
                end
            end
            default:
            begin
                state_nxt.st = ST_SEQ;
                state_nxt.cnt = hims_pkg::RST_SEQ_LEN;
            end
        endcase
        // Without the queue each word must drain before the next one
        if (state_nxt.st != ST_RUN)
            state_nxt.busy_n = 1'b0;
        else if (state_r.fifo_on)
            state_nxt.busy_n = f_ready & (f_cnt < hims_pkg::FIFO_AFULL);
        else
            state_nxt.busy_n = (f_cnt == 4'h0) & !state_r.ov
                & !state_r.push;
    end
    // =========================================================
    // State register, reset starts the busy sequence
    always_ff @(negedge link_clk_i)
    begin
        if (!resetn_i)
        begin
            state_r <= '0;
            state_r.st <= ST_SEQ;
            state_r.cnt <= hims_pkg::RST_SEQ_LEN;
            state_r.ack_oe_n <= 1'b1;
        end
        else if (ce_i)
            state_r <= state_nxt;
    end
endmodule

//--- rtl/hims_fifo.sv
// Purpose: small word queue with valid and ready on both sides
// Assumes: one clock, synchronous active low reset
// Notes: count output lets the owner signal back-pressure early
`timescale 1ns/100ps
module hims_fifo #(
    parameter int W = 24,
    parameter int DEPTH = 8
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic in_valid_i,
    input wire logic [W-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [W-1:0] out_data_o,
    input wire logic out_ready_i,
    output logic [$clog2(DEPTH):0] count_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [$clog2(DEPTH):0] cnt;
    } hims_fifo_type;
    hims_fifo_type state_r;
    hims_fifo_type state_nxt;
    logic push;
    logic pop;
    // =========================================================
    // Honest flags straight from the count
    assign in_ready_o = (state_r.cnt != ($clog2(DEPTH) + 1)'(DEPTH));
    assign out_valid_o = (state_r.cnt != '0);
    assign out_data_o = state_r.mem[state_r.rp];
    assign count_o = state_r.cnt;
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;
    // Pointer and count update
    always_comb
    begin
        state_nxt = state_r;
        if (push)
        begin
            state_nxt.mem[state_r.wp] = in_data_i;
            state_nxt.wp = (state_r.wp == AW'(DEPTH - 1)) ? '0
                : state_r.wp + 1'b1;
        end
        if (pop)
            state_nxt.rp = (state_r.rp == AW'(DEPTH - 1)) ? '0
                : state_r.rp + 1'b1;
        if (push & !pop)
            state_nxt.cnt = state_r.cnt + 1'b1;
        else if (pop & !push)
            state_nxt.cnt = state_r.cnt - 1'b1;
    end
    // Register, frozen while ce_i is low
    always_ff @(posedge clock_i)
    begin
        if (!resetn_i)
            state_r <= '0;
        else if (ce_i)
            state_r <= state_nxt;
    end
endmodule

//--- rtl/hims_host.sv
// Purpose: host end, drives mode pins, words and link clock
// Assumes: user holds word_valid_i until word_ready_o pulses
// Notes: pins change only on rising link clock events
`timescale 1ns/100ps
module hims_host (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    hims_link_if.host lnk,
    input wire logic [1:0] mode_i,
    input wire logic fifo_en_i,
    input wire logic i2c_fast_i,
    input wire logic [hims_pkg::WORD_W-1:0] word_i,
    input wire logic word_valid_i,
    output logic word_ready_o,
    input wire logic load_i,
    input wire logic reset_i,
    input wire logic clear_i,
    output logic idle_o
);
    typedef enum logic [4:0] {
        HS_RST = 5'b00001,
        HS_WAIT = 5'b00010,
        HS_IDLE = 5'b00100,
        HS_PAR = 5'b01000,
        HS_SER = 5'b10000
    } hims_hst_type;
    typedef struct packed {
        hims_hst_type st;
        logic [7:0] div;
        logic lclk;
        logic [4:0] cnt;
        logic [1:0] mode;
        logic fast;
        logic [hims_pkg::WORD_W-1:0] word;
        hims_pkg::hims_pins_type pins;
        logic oe_n;
        logic busy1;
        logic busy2;
        logic taken;
        logic p_load;
        logic p_rst;
        logic p_clr;
        logic clr_op;
    } hims_host_type;
    hims_host_type state_r;
    hims_host_type state_nxt;
    logic [7:0] half;
    logic rise;
    logic is_i2c;
    // =========================================================
    // Link clock divider, rate by mode
    assign half = (state_r.mode != hims_pkg::MODE_I2C) ? hims_pkg::SPI_HALF
        : (state_r.fast ? hims_pkg::I2C_FAST_HALF : hims_pkg::I2C_STD_HALF);
    assign rise = (state_r.div == half - 8'h01) & !state_r.lclk;
    assign is_i2c = (state_r.mode == hims_pkg::MODE_I2C);
    assign lnk.link_clk = state_r.lclk;
    assign lnk.host_pins = state_r.pins;
    assign lnk.host_serial_data_bit_thirteen_oe_n = state_r.oe_n;
    assign word_ready_o = state_r.taken;
    assign idle_o = (state_r.st == HS_IDLE);
    // =========================================================
    // Next state
    always_comb
    begin
        state_nxt = state_r;
        state_nxt.taken = 1'b0;
        // Busy comes from the link domain, two flops first
        state_nxt.busy1 = lnk.dev_busy_n;
        state_nxt.busy2 = state_r.busy1;
        state_nxt.p_load = state_r.p_load | load_i;
        state_nxt.p_rst = state_r.p_rst | reset_i;
        state_nxt.p_clr = state_r.p_clr | clear_i;
        if (state_r.div == half - 8'h01)
        begin
            state_nxt.div = 8'h00;
            state_nxt.lclk = !state_r.lclk;
        end
        else
            state_nxt.div = state_r.div + 8'h01;
        if (rise)
        begin
            state_nxt.pins.load_n = 1'b1;
            case (state_r.st)
                HS_RST:
                begin
                    // RULE_16 - mode taken only in reset
                    if (!state_r.clr_op)
                    begin
                        state_nxt.mode = mode_i;
                        state_nxt.fast = i2c_fast_i;
                        state_nxt.pins.serial_parallel_select =
                            (mode_i != hims_pkg::MODE_PAR);
                        state_nxt.pins.db[11] =
                            (mode_i == hims_pkg::MODE_I2C);
                        // RULE_04 - strap low in serial
                        state_nxt.pins.strap = fifo_en_i
                            & (mode_i == hims_pkg::MODE_PAR);
                        state_nxt.oe_n = (mode_i == hims_pkg::MODE_I2C);
                    end
                    if (state_r.cnt != 5'h0000)
                        state_nxt.cnt = state_r.cnt - 1'b1;
                    else
                    begin
                        state_nxt.pins.rst_n = 1'b1;
                        state_nxt.pins.clr_n = 1'b1;
                        state_nxt.cnt = hims_pkg::GUARD_LEN;
                        state_nxt.st = HS_WAIT;
                    end
                end
                HS_WAIT:
                begin
                    // Guard covers the busy round trip
                    if (state_r.cnt != 5'h0000)
                        state_nxt.cnt = state_r.cnt - 1'b1;
                    else if (state_r.busy2)
                        state_nxt.st = HS_IDLE;
                end
                HS_IDLE:
                begin
                    if (state_r.p_rst | state_r.p_clr)
                    begin
                        state_nxt.st = HS_RST;
                        state_nxt.cnt = hims_pkg::RST_HOLD;
                        state_nxt.clr_op = !state_r.p_rst;
                        state_nxt.pins.rst_n = !state_r.p_rst;
                        state_nxt.pins.clr_n = state_r.p_rst;
                        // New requests of this cycle stay pending
                        state_nxt.p_rst = reset_i;
                        state_nxt.p_clr = clear_i;
                    end
                    else if (state_r.p_load)
                    begin
                        state_nxt.pins.load_n = 1'b0;
                        state_nxt.p_load = load_i;
                    end
                    else if (word_valid_i)
                    begin
                        state_nxt.taken = 1'b1;
                        state_nxt.word = word_i;
                        state_nxt.cnt = 5'h0000;
                        if (state_r.mode == hims_pkg::MODE_PAR)
                        begin
                            state_nxt.pins.db = word_i[13:0];
                            state_nxt.pins.wr_n = 1'b0;
                            state_nxt.st = HS_PAR;
                        end
                        else
                        begin
                            state_nxt.pins.frame_n = 1'b0;
                            state_nxt.pins.db[13] = !is_i2c & word_i[23];
                            state_nxt.oe_n = is_i2c & word_i[23];
                            state_nxt.st = HS_SER;
                        end
                    end
                end
                HS_PAR:
                begin
                    state_nxt.pins.wr_n = 1'b1;
                    state_nxt.cnt = hims_pkg::GUARD_LEN;
                    state_nxt.st = HS_WAIT;
                end
                HS_SER:
                begin
                    // RULE_13 - bit changes on rising edge only
                    state_nxt.word = {state_r.word[22:0], 1'b0};
                    if (state_r.cnt == hims_pkg::WORD_LAST)
                    begin
                        state_nxt.pins.frame_n = 1'b1;
                        state_nxt.pins.db[13] = 1'b0;
                        state_nxt.oe_n = is_i2c;
                        state_nxt.cnt = hims_pkg::GUARD_LEN;
                        state_nxt.st = HS_WAIT;
                    end
                    else
                    begin
                        state_nxt.cnt = state_r.cnt + 1'b1;
                        state_nxt.pins.db[13] = !is_i2c & state_r.word[22];
                        state_nxt.oe_n = is_i2c & state_r.word[22];
                    end
                end
                default:
                    state_nxt.st = HS_RST;
            endcase
        end
    end
    // =========================================================
    // RULE_10 - divider keeps link under limit
    // RULE_11 - I2C rate from fast select
    always_ff @(posedge clock_i)
    begin
        if (!resetn_i)
        begin
            state_r <= '0;
            state_r.st <= HS_RST;
            state_r.cnt <= hims_pkg::RST_HOLD;
            state_r.pins.wr_n <= 1'b1;
            state_r.pins.frame_n <= 1'b1;
            state_r.pins.load_n <= 1'b1;
            state_r.pins.clr_n <= 1'b1;
        end
        else if (ce_i)
            state_r <= state_nxt;
    end
endmodule
